// ==== hw/rps_pkg.sv ====
// Constants, register map and helpers for the remappable pin select block
//-----------------------------------------------------------------------------
// Function
// [R1] Fault select high byte routes pin to fault 4
// [R2] Fault select low byte routes pin to fault 3
// [R3] Serial select high byte feeds clear-to-send
// [R4] Serial select low byte feeds receive data
// [R5] Output select bits 14-8 drive pin 53
// [R6] Output select bits 6-0 drive pin 52
// [R7] Output select bits 15, 7 read zero
// [R8] Selection fields reset zero, read/write
// [R9] Port E per-pin control fields provided
// [R10] Function zero leaves pin under port control
//-----------------------------------------------------------------------------
package rps_pkg;

  //---------------------------------------------------------------------------
  // Widths
  //---------------------------------------------------------------------------
  localparam int AW    = 12;
  localparam int DW    = 32;
  localparam int RW    = 16;
  localparam int IDX_W = 8;
  localparam int FN_W  = 7;
  localparam int N_RP  = 256;
  localparam int N_FN  = 128;

  //---------------------------------------------------------------------------
  // Register byte offsets
  //---------------------------------------------------------------------------
  localparam logic [AW-1:0] OFF_DIR  = 12'h000;
  localparam logic [AW-1:0] OFF_PORT = 12'h004;
  localparam logic [AW-1:0] OFF_LAT  = 12'h008;
  localparam logic [AW-1:0] OFF_ODC  = 12'h00c;
  localparam logic [AW-1:0] OFF_CNE  = 12'h010;
  localparam logic [AW-1:0] OFF_PUE  = 12'h014;
  localparam logic [AW-1:0] OFF_PDE  = 12'h018;
  localparam logic [AW-1:0] OFF_ANS  = 12'h01c;
  localparam logic [AW-1:0] OFF_FSEL = 12'h020;
  localparam logic [AW-1:0] OFF_SSEL = 12'h024;
  localparam logic [AW-1:0] OFF_OSEL = 12'h028;

  //---------------------------------------------------------------------------
  // Field positions
  //---------------------------------------------------------------------------
  localparam int HI_IDX_LSB = 8;
  localparam int LO_IDX_LSB = 0;
  localparam int P53_LSB    = 8;
  localparam int P52_LSB    = 0;
  localparam logic [RW-1:0] OSEL_MASK = 16'h7f7f;

  //---------------------------------------------------------------------------
  // Values after reset
  //---------------------------------------------------------------------------
  localparam logic [RW-1:0] DIR_RST  = 16'hffff;
  localparam logic [RW-1:0] ZERO_RST = 16'h0000;
  localparam logic [DW-1:0] RD_RST   = 32'h0000_0000;

  //---------------------------------------------------------------------------
  // Block state
  //---------------------------------------------------------------------------
  typedef struct packed {
    logic [RW-1:0] dir;
    logic [RW-1:0] lat;
    logic [RW-1:0] odc;
    logic [RW-1:0] cne;
    logic [RW-1:0] pue;
    logic [RW-1:0] pde;
    logic [RW-1:0] oe_n;
    logic [RW-1:0] fsel;
    logic [RW-1:0] ssel;
    logic [RW-1:0] osel;
    logic [DW-1:0] rdata;
  } rps_regs_s;

  // Byte-lane merge of a 16-bit register
  function automatic logic [RW-1:0] merge16(input logic [RW-1:0] old,
                                            input logic [DW-1:0] wd,
                                            input logic [3:0]    strb);
    logic [RW-1:0] r;
    r       = old;
    if (strb[0]) r[7:0]  = wd[7:0];
    if (strb[1]) r[15:8] = wd[15:8];
    return r;
  endfunction : merge16

  // Address decode
  function automatic logic mapped(input logic [AW-1:0] a);
    return (a[1:0] == 2'h0) && (a <= OFF_OSEL);
  endfunction : mapped

endpackage : rps_pkg

// ==== hw/rps_sel_if.sv ====
// Selector bundle between the pin select top and its multiplexers
`timescale 1ns/1ps
interface rps_sel_if #(
  parameter int W = 8,
  parameter int N = 256
);
  logic [W-1:0] sel;
  logic [N-1:0] src;
  logic         alt;
  logic         y;
  logic         act;

  modport mgr_in  (output sel, src, input y);
  modport in_mux  (input sel, src, output y);
  modport mgr_out (output sel, src, alt, input y, act);
  modport out_mux (input sel, src, alt, output y, act);
endinterface : rps_sel_if

// ==== hw/rps_in_sel.sv ====
// Registered remappable pin to peripheral input multiplexer
`timescale 1ns/1ps
module rps_in_sel (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Selector
  rps_sel_if.in_mux bus
);
  typedef struct packed {
    logic y;
  } rps_in_st_s;

  rps_in_st_s st_reg;
  rps_in_st_s st_next;

  always_comb begin
    st_next   = st_reg;
    st_next.y = bus.src[bus.sel];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.y = st_reg.y;
endmodule : rps_in_sel

// ==== hw/rps_out_sel.sv ====
// Registered peripheral function to remappable output pin multiplexer
`timescale 1ns/1ps
module rps_out_sel (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Selector
  rps_sel_if.out_mux bus
);
  typedef struct packed {
    logic y;
    logic act;
  } rps_out_st_s;

  rps_out_st_s st_reg;
  rps_out_st_s st_next;

  always_comb begin
    st_next     = st_reg;
    st_next.act = (bus.sel != '0);
    // Function zero hands the pin back to ordinary port logic
    st_next.y   = st_next.act ? bus.src[bus.sel] : bus.alt; // [R10]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.y   = st_reg.y;
  assign bus.act = st_reg.act;
endmodule : rps_out_sel

// ==== hw/rps_top.sv ====
// Remappable pin select and port E control with an APB register slave
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
module rps_top (
  // Clock and reset
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  // APB slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [rps_pkg::AW-1:0]          paddr,
  input  wire logic [rps_pkg::DW-1:0]          pwdata,
  input  wire logic [3:0]                      pstrb,
  output      logic [rps_pkg::DW-1:0]          prdata,
  output      logic                            pready,
  output      logic                            pslverr,
  // Port E pads
  input  wire logic [rps_pkg::RW-1:0]          port_e_pin_bits,
  output      logic [rps_pkg::RW-1:0]          port_e_out,
  output      logic [rps_pkg::RW-1:0]          port_e_oe_n,
  output      logic [rps_pkg::RW-1:0]          port_e_change_notify_bits,
  output      logic [rps_pkg::RW-1:0]          port_e_pull_up_enable,
  output      logic [rps_pkg::RW-1:0]          port_e_pull_down_enable,
  // Remappable inputs to peripherals
  input  wire logic [rps_pkg::N_RP-1:0]        remappable_pin_in,
  output      logic                            pwm_fault_input_4,
  output      logic                            pwm_fault_input_3,
  output      logic                            serial_clear_to_send_in,
  output      logic                            serial_receive_in,
  // Peripheral outputs to remappable pins
  input  wire logic [rps_pkg::N_FN-1:0]        periph_out_fn,
  input  wire logic                            rp52_port_out,
  input  wire logic                            rp53_port_out,
  output      logic                            rp52_out,
  output      logic                            rp53_out,
  output      logic                            rp52_fn_active,
  output      logic                            rp53_fn_active
);

  //---------------------------------------------------------------------------
  // State
  //---------------------------------------------------------------------------
  rps_pkg::rps_regs_s st_reg;
  rps_pkg::rps_regs_s st_next;

  logic                   setup;
  logic                   access;
  logic                   hit;
  logic [rps_pkg::RW-1:0] rd_val;

  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign hit    = rps_pkg::mapped(paddr);

  //---------------------------------------------------------------------------
  // APB answer
  //---------------------------------------------------------------------------
  // Zero wait states: read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access && !hit;
  assign prdata  = st_reg.rdata;

  //---------------------------------------------------------------------------
  // Read multiplexer
  //---------------------------------------------------------------------------
  always_comb begin
    rd_val = '0;
    case (paddr)
      rps_pkg::OFF_DIR:  rd_val = st_reg.dir;
      rps_pkg::OFF_PORT: rd_val = port_e_pin_bits; // [R9]
      rps_pkg::OFF_LAT:  rd_val = st_reg.lat;
      rps_pkg::OFF_ODC:  rd_val = st_reg.odc;
      rps_pkg::OFF_CNE:  rd_val = st_reg.cne;
      rps_pkg::OFF_PUE:  rd_val = st_reg.pue;
      rps_pkg::OFF_PDE:  rd_val = st_reg.pde;
      rps_pkg::OFF_FSEL: rd_val = st_reg.fsel; // [R8]
      rps_pkg::OFF_SSEL: rd_val = st_reg.ssel; // [R8]
      rps_pkg::OFF_OSEL: rd_val = st_reg.osel & rps_pkg::OSEL_MASK; // [R7]
      default:           rd_val = '0;
    endcase
  end

  //---------------------------------------------------------------------------
  // Next state
  //---------------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    if (setup && !pwrite) begin
      st_next.rdata = {16'h0000, rd_val};
    end
    if (access && pwrite && hit) begin
      case (paddr)
        rps_pkg::OFF_DIR: begin
          st_next.dir = rps_pkg::merge16(st_reg.dir, pwdata, pstrb); // [R9]
        end
        // A write to the pin value lands in the output latch
        rps_pkg::OFF_PORT, rps_pkg::OFF_LAT: begin
          st_next.lat = rps_pkg::merge16(st_reg.lat, pwdata, pstrb); // [R9]
        end
        rps_pkg::OFF_ODC: begin
          st_next.odc = rps_pkg::merge16(st_reg.odc, pwdata, pstrb); // [R9]
        end
        rps_pkg::OFF_CNE: begin
          st_next.cne = rps_pkg::merge16(st_reg.cne, pwdata, pstrb); // [R9]
        end
        rps_pkg::OFF_PUE: begin
          st_next.pue = rps_pkg::merge16(st_reg.pue, pwdata, pstrb); // [R9]
        end
        rps_pkg::OFF_PDE: begin
          st_next.pde = rps_pkg::merge16(st_reg.pde, pwdata, pstrb); // [R9]
        end
        rps_pkg::OFF_FSEL: begin
          st_next.fsel = rps_pkg::merge16(st_reg.fsel, pwdata, pstrb); // [R8]
        end
        rps_pkg::OFF_SSEL: begin
          st_next.ssel = rps_pkg::merge16(st_reg.ssel, pwdata, pstrb); // [R8]
        end
        rps_pkg::OFF_OSEL: begin
          st_next.osel = rps_pkg::merge16(st_reg.osel, pwdata, pstrb)
                         & rps_pkg::OSEL_MASK; // [R7]
        end
        // Analog select has no implemented bits; writes are dropped
        default: begin
          st_next.osel = st_next.osel;
        end
      endcase
    end
    // Open drain only ever pulls low, so a high latch releases the pad
    st_next.oe_n = st_next.dir | (st_next.odc & st_next.lat); // [R9]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg       <= '0; // [R8]
      st_reg.dir   <= rps_pkg::DIR_RST;
      st_reg.oe_n  <= rps_pkg::DIR_RST;
      st_reg.rdata <= rps_pkg::RD_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  //---------------------------------------------------------------------------
  // Port E pads
  //---------------------------------------------------------------------------
  assign port_e_out                = st_reg.lat;
  assign port_e_oe_n               = st_reg.oe_n;
  assign port_e_change_notify_bits = st_reg.cne;
  assign port_e_pull_up_enable     = st_reg.pue;
  assign port_e_pull_down_enable   = st_reg.pde;

  //---------------------------------------------------------------------------
  // Input routing
  //---------------------------------------------------------------------------
  rps_sel_if #(.W(rps_pkg::IDX_W), .N(rps_pkg::N_RP)) in_if [4] ();
  logic [rps_pkg::IDX_W-1:0] in_idx [4];

  assign in_idx[0] = st_reg.fsel[rps_pkg::HI_IDX_LSB +: rps_pkg::IDX_W]; // [R1]
  assign in_idx[1] = st_reg.fsel[rps_pkg::LO_IDX_LSB +: rps_pkg::IDX_W]; // [R2]
  assign in_idx[2] = st_reg.ssel[rps_pkg::HI_IDX_LSB +: rps_pkg::IDX_W]; // [R3]
  assign in_idx[3] = st_reg.ssel[rps_pkg::LO_IDX_LSB +: rps_pkg::IDX_W]; // [R4]

  for (genvar g = 0; g < 4; g++) begin : g_in
    assign in_if[g].sel = in_idx[g];
    assign in_if[g].src = remappable_pin_in;
    rps_in_sel u_in (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (in_if[g])
    );
  end

  assign pwm_fault_input_4       = in_if[0].y;
  assign pwm_fault_input_3       = in_if[1].y;
  assign serial_clear_to_send_in = in_if[2].y;
  assign serial_receive_in       = in_if[3].y;

  //---------------------------------------------------------------------------
  // Output routing
  //---------------------------------------------------------------------------
  rps_sel_if #(.W(rps_pkg::FN_W), .N(rps_pkg::N_FN)) p53_if ();
  rps_sel_if #(.W(rps_pkg::FN_W), .N(rps_pkg::N_FN)) p52_if ();

  assign p53_if.sel = st_reg.osel[rps_pkg::P53_LSB +: rps_pkg::FN_W]; // [R5]
  assign p53_if.src = periph_out_fn;
  assign p53_if.alt = rp53_port_out;
  assign p52_if.sel = st_reg.osel[rps_pkg::P52_LSB +: rps_pkg::FN_W]; // [R6]
  assign p52_if.src = periph_out_fn;
  assign p52_if.alt = rp52_port_out;

  rps_out_sel u_p53 (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (p53_if)
  );

  rps_out_sel u_p52 (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (p52_if)
  );

  assign rp53_out       = p53_if.y;
  assign rp53_fn_active = p53_if.act;
  assign rp52_out       = p52_if.y;
  assign rp52_fn_active = p52_if.act;

  //---------------------------------------------------------------------------
  // Checks
  //---------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic                   f4_exp;
  logic                   f3_exp;
  logic                   cts_exp;
  logic                   rx_exp;
  logic                   p53_exp;
  logic                   p52_exp;
  logic                   p52_idle;
  logic [rps_pkg::RW-1:0] wd16;
  logic                   full_wr;

  assign f4_exp   = remappable_pin_in[st_reg.fsel[15:8]];
  assign f3_exp   = remappable_pin_in[st_reg.fsel[7:0]];
  assign cts_exp  = remappable_pin_in[st_reg.ssel[15:8]];
  assign rx_exp   = remappable_pin_in[st_reg.ssel[7:0]];
  assign p53_exp  = periph_out_fn[st_reg.osel[14:8]];
  assign p52_exp  = periph_out_fn[st_reg.osel[6:0]];
  assign p52_idle = (st_reg.osel[6:0] == 7'h00);
  assign wd16     = pwdata[15:0];
  assign full_wr  = access && pwrite && (pstrb[1:0] == 2'h3);

  chk_fault4_route: assert property ( // [R1]
    $past(presetn) |-> pwm_fault_input_4 == $past(f4_exp))
    else $error("fault 4 input not routed from selected pin");

  chk_fault3_route: assert property ( // [R2]
    $past(presetn) |-> pwm_fault_input_3 == $past(f3_exp))
    else $error("fault 3 input not routed from selected pin");

  chk_cts_route: assert property ( // [R3]
    $past(presetn) |-> serial_clear_to_send_in == $past(cts_exp))
    else $error("clear-to-send not routed from selected pin");

  chk_rx_route: assert property ( // [R4]
    $past(presetn) |-> serial_receive_in == $past(rx_exp))
    else $error("receive data not routed from selected pin");

  chk_pin53_drive: assert property ( // [R5]
    ($past(presetn) && rp53_fn_active) |-> rp53_out == $past(p53_exp))
    else $error("pin 53 not driven by selected function");

  chk_pin52_drive: assert property ( // [R6]
    ($past(presetn) && rp52_fn_active) |-> rp52_out == $past(p52_exp))
    else $error("pin 52 not driven by selected function");

  chk_osel_unimpl_bits: assert property ( // [R7]
    (setup && !pwrite && paddr == rps_pkg::OFF_OSEL)
      |=> (prdata[15] == 1'b0) && (prdata[7] == 1'b0))
    else $error("unimplemented output select bits read nonzero");

  chk_fsel_write_read: assert property ( // [R8]
    (full_wr && paddr == rps_pkg::OFF_FSEL)
      |=> st_reg.fsel == $past(wd16) ##1 st_reg.fsel == $past(wd16, 2))
    else $error("fault select write not held");

  chk_port_write_latch: assert property ( // [R9]
    (full_wr && paddr == rps_pkg::OFF_PORT) |=> port_e_out == $past(wd16))
    else $error("port write did not reach the output latch");

  chk_pin52_port_ctrl: assert property ( // [R10]
    ($past(presetn) && $past(p52_idle))
      |-> !rp52_fn_active && rp52_out == $past(rp52_port_out))
    else $error("pin 52 not under port control with function zero");

  // A refused transfer must leave every register untouched
  chk_apb_unmapped: assert property (
    (access && !hit) |-> pslverr && pready ##1 $stable(st_reg))
    else $error("unmapped access not answered with an error");

  // Read path: data is taken at the setup edge and stands in the access cycle
  chk_rdata_upper_zero: assert property (
    prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");

  chk_fsel_read_capture: assert property ( // [R8]
    (setup && !pwrite && paddr == rps_pkg::OFF_FSEL) |=> prdata[15:0] == $past(st_reg.fsel))
    else $error("fault select read not captured at setup");

  chk_pin_value_read: assert property ( // [R9]
    (setup && !pwrite && paddr == rps_pkg::OFF_PORT) |=> prdata[15:0] == $past(port_e_pin_bits))
    else $error("pin value read does not show the pads");

  chk_analog_read_zero: assert property ( // [R9]
    (setup && !pwrite && paddr == rps_pkg::OFF_ANS) |=> prdata == 32'h0000_0000)
    else $error("analog select read nonzero");

  // Write path: full writes land, partial writes keep the other lane
  chk_ssel_write_read: assert property ( // [R8]
    (full_wr && paddr == rps_pkg::OFF_SSEL) |=> st_reg.ssel == $past(wd16))
    else $error("serial select write not held");

  chk_osel_write_mask: assert property ( // [R7]
    (full_wr && paddr == rps_pkg::OFF_OSEL) |=> st_reg.osel == ($past(wd16) & 16'h7f7f))
    else $error("output select write not masked");

  chk_osel_unimpl_held: assert property ( // [R7]
    (st_reg.osel[15] == 1'b0) && (st_reg.osel[7] == 1'b0))
    else $error("unimplemented output select bits set");

  chk_lane_keep_high: assert property ( // [R8]
    (access && pwrite && paddr == rps_pkg::OFF_FSEL && pstrb[1:0] == 2'h1)
      |=> st_reg.fsel[15:8] == $past(st_reg.fsel[15:8]))
    else $error("fault select high lane changed by low lane write");

  chk_lane_keep_low: assert property ( // [R8]
    (access && pwrite && paddr == rps_pkg::OFF_FSEL && pstrb[1:0] == 2'h2)
      |=> st_reg.fsel[7:0] == $past(st_reg.fsel[7:0]))
    else $error("fault select low lane changed by high lane write");

  // Port E pads follow their registers; pin 53 returns to port control at function zero
  chk_dir_write_read: assert property ( // [R9]
    (full_wr && paddr == rps_pkg::OFF_DIR) |=> st_reg.dir == $past(wd16))
    else $error("direction write not held");

  chk_lat_write_pads: assert property ( // [R9]
    (full_wr && paddr == rps_pkg::OFF_LAT) |=> port_e_out == $past(wd16))
    else $error("latch write did not reach the pads");

  chk_oe_n_drive: assert property ( // [R9]
    port_e_oe_n == (st_reg.dir | (st_reg.odc & port_e_out)))
    else $error("pad enable does not follow direction and open drain");

  chk_pin53_port_ctrl: assert property ( // [R10]
    ($past(presetn) && $past(st_reg.osel[14:8] == 7'h00))
      |-> !rp53_fn_active && rp53_out == $past(rp53_port_out))
    else $error("pin 53 not under port control with function zero");

  cov_fsel_write: cover property (full_wr && paddr == rps_pkg::OFF_FSEL);
  cov_osel_read:  cover property (setup && !pwrite && paddr == rps_pkg::OFF_OSEL);
  cov_p53_active: cover property (!rp53_fn_active ##1 rp53_fn_active);
  cov_unmapped:   cover property (pslverr);
  cov_p52_port:   cover property (p52_idle ##1 !rp52_fn_active);

endmodule : rps_top

// ==== sim/rps_pin_model.sv ====
// Model of the remappable pins and peripheral outputs around the block
`timescale 1ns/1ps
module rps_pin_model (
  // Clock
  input  wire logic                     pclk,
  // Remappable pin levels and peripheral output functions
  output      logic [rps_pkg::N_RP-1:0] remappable_pin_in,
  output      logic [rps_pkg::N_FN-1:0] periph_out_fn,
  // Ordinary port drive of pins 52 and 53
  output      logic                     rp52_port_out,
  output      logic                     rp53_port_out
);
  // A fresh pattern every cycle, so a stale select or a late sample shows up
  initial begin
    remappable_pin_in = '0;
    periph_out_fn = '0;
    rp52_port_out = 1'b0;
    rp53_port_out = 1'b0;
    forever begin
      @(posedge pclk);
      for (int i = 0; i < 8; i++) remappable_pin_in[i*32 +: 32] <= $urandom;
      for (int i = 0; i < 4; i++) periph_out_fn[i*32 +: 32] <= $urandom;
      {rp53_port_out, rp52_port_out} <= 2'($urandom);
    end
  end
endmodule : rps_pin_model

// ==== sim/remappable_pin_select_tb.sv ====
// Self-checking bench for the remappable pin select block
`timescale 1ns/1ps
module remappable_pin_select_tb;
  logic                     pclk;
  logic                     presetn;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [rps_pkg::AW-1:0]   paddr;
  logic [rps_pkg::DW-1:0]   pwdata;
  logic [3:0]               pstrb;
  logic [rps_pkg::DW-1:0]   prdata;
  logic                     pready;
  logic                     pslverr;
  logic [rps_pkg::RW-1:0]   port_e_pin_bits;
  logic [rps_pkg::RW-1:0]   pe_o [5];
  logic [rps_pkg::N_RP-1:0] remappable_pin_in;
  logic [rps_pkg::N_FN-1:0] periph_out_fn;
  logic                     rp52_port_out;
  logic                     rp53_port_out;
  logic [7:0]               route_o;
  logic [32:0]              aq [$];
  logic [7:0]               rq [$];
  logic [15:0]              sh [3];
  logic                     run_route;
  int                       failures;
  int                       comparisons;

  rps_top uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .port_e_pin_bits,
    .port_e_out(pe_o[0]), .port_e_oe_n(pe_o[1]), .port_e_change_notify_bits(pe_o[2]),
    .port_e_pull_up_enable(pe_o[3]), .port_e_pull_down_enable(pe_o[4]),
    .remappable_pin_in, .pwm_fault_input_4(route_o[7]), .pwm_fault_input_3(route_o[6]),
    .serial_clear_to_send_in(route_o[5]), .serial_receive_in(route_o[4]),
    .periph_out_fn, .rp52_port_out, .rp53_port_out,
    .rp53_out(route_o[3]), .rp52_out(route_o[2]),
    .rp53_fn_active(route_o[1]), .rp52_fn_active(route_o[0])
  );

  rps_pin_model pins (
    .pclk, .remappable_pin_in, .periph_out_fn, .rp52_port_out, .rp53_port_out
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  //---------------------------------------------------------------------------
  // Compare, bus and closing tasks
  //---------------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [31:0] exp, input logic err);
    int n;
    logic [15:0] v;
    aq.push_back({err, exp});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 50) failures++;
    psel <= 1'b0;
    penable <= 1'b0;
    // Selection shadow follows only writes that the block accepts
    if (wr && !err && a >= 12'h020) begin
      v = sh[(a - 12'h020) >> 2];
      if (s[0]) v[7:0] = d[7:0];
      if (s[1]) v[15:8] = d[15:8];
      sh[(a - 12'h020) >> 2] = (a == 12'h028) ? (v & 16'h7f7f) : v;
    end
  endtask : apb

  task automatic summarize();
    $display("Counts: comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  //---------------------------------------------------------------------------
  // Result watchers
  //---------------------------------------------------------------------------
  always @(posedge pclk) begin
    logic [32:0] note;
    if (presetn && psel && penable && pready === 1'b1 && aq.size() > 0) begin
      note = aq.pop_front();
      check("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
      if (!pwrite) check("prdata", note[31:0], prdata);
    end
  end

  // Next edge routes the sources seen now through the selects seen now
  always @(negedge pclk) begin
    if (run_route) begin
      rq.push_back({remappable_pin_in[sh[0][15:8]], remappable_pin_in[sh[0][7:0]],
                    remappable_pin_in[sh[1][15:8]], remappable_pin_in[sh[1][7:0]],
                    (sh[2][14:8] != 0) ? periph_out_fn[sh[2][14:8]] : rp53_port_out,
                    (sh[2][6:0] != 0) ? periph_out_fn[sh[2][6:0]] : rp52_port_out,
                    |sh[2][14:8], |sh[2][6:0]});
    end
  end

  always @(posedge pclk) begin
    if (rq.size() > 0) begin
      #1;
      check("route", {24'h0, rq.pop_front()}, {24'h0, route_o});
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    $display("Watchdog expired");
    summarize();
  end

  //---------------------------------------------------------------------------
  // Tests
  //---------------------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [31:0] e;
    logic [15:0] pv [6];
    logic [11:0] offs [6];
    offs = '{12'h000, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018};
    {presetn, psel, penable, pwrite, run_route} = '0;
    {paddr, pwdata, pstrb, port_e_pin_bits} = '0;
    sh = '{default: 16'h0000};
    failures = 0;
    comparisons = 0;
    void'($urandom(30814));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    run_route <= 1'b1;
    for (int i = 0; i < 11; i++) apb(0, 12'(i*4), 0, 0, (i == 0) ? 32'h0000_ffff : 0, 0);
    $display("Test reset values done");
    @(posedge pclk);
    port_e_pin_bits <= 16'($urandom);
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      pv[i] = d[15:0];
      apb(1, offs[i], d, 4'hf, 0, 0);
    end
    for (int i = 0; i < 6; i++) apb(0, offs[i], 0, 0, {16'h0, pv[i]}, 0);
    apb(0, 12'h004, 0, 0, {16'h0, port_e_pin_bits}, 0);
    check("port_e_out", {16'h0, pv[1]}, {16'h0, pe_o[0]});
    check("port_e_oe_n", {16'h0, pv[0] | (pv[2] & pv[1])}, {16'h0, pe_o[1]});
    check("change_notify", {16'h0, pv[3]}, {16'h0, pe_o[2]});
    check("pull_up", {16'h0, pv[4]}, {16'h0, pe_o[3]});
    check("pull_down", {16'h0, pv[5]}, {16'h0, pe_o[4]});
    apb(1, 12'h004, 32'h0000_5a3c, 4'hf, 0, 0);
    apb(0, 12'h008, 0, 0, 32'h0000_5a3c, 0);
    apb(1, 12'h01c, 32'hffff_ffff, 4'hf, 0, 0);
    apb(0, 12'h01c, 0, 0, 0, 0);
    $display("Test port E done");
    apb(0, 12'h02c, 0, 0, 0, 1);
    apb(0, 12'h001, 0, 0, 0, 1);
    apb(1, 12'h021, 32'hffff_ffff, 4'hf, 0, 1);
    apb(0, 12'h020, 0, 0, 0, 0);
    apb(1, 12'h028, 32'hffff_ffff, 4'hf, 0, 0);
    apb(0, 12'h028, 0, 0, 32'h0000_7f7f, 0);
    apb(1, 12'h020, 32'h0000_a5c3, 4'b0010, 0, 0);
    apb(0, 12'h020, 0, 0, 32'h0000_a500, 0);
    apb(1, 12'h020, 32'h0000_ffc3, 4'b0001, 0, 0);
    apb(0, 12'h020, 0, 0, 32'h0000_a5c3, 0);
    $display("Test unmapped and lanes done");
    for (int k = 0; k < 40; k++) begin
      d = (k == 0) ? 32'hffff_ffff : (k == 1) ? 32'h0 : $urandom;
      e = (k == 0) ? 32'hffff_ffff : $urandom;
      if (k[2]) e[6:0] = 7'h00;
      if (k[3]) e[14:8] = 7'h00;
      apb(1, 12'h020, d, 4'hf, 0, 0);
      apb(1, 12'h024, {d[7:0], d[15:8], e[23:8]}, 4'hf, 0, 0);
      apb(1, 12'h028, e, 4'hf, 0, 0);
      repeat (3) @(posedge pclk);
      apb(0, 12'h024, 0, 0, {16'h0, sh[1]}, 0);
      apb(0, 12'h028, 0, 0, {16'h0, sh[2]}, 0);
    end
    $display("Test routing done");
    repeat (3) @(posedge pclk);
    summarize();
  end
endmodule : remappable_pin_select_tb
